// File: core_model.sv
`timescale 1ns/10ps

// ==========================================================================
// Core model: acknowledges a presented request while willing to take it.
// ==========================================================================
module core_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Handshake
  input  wire logic irq_req_i,
  input  wire logic take_i,
  output logic      ack_o
);
  initial ack_o = 1'b0;
  // One pulse per presented request; a slow core simply holds take_i low.
  always @(posedge ref_clk_i)
  begin
    ack_o <= #1 rst_n_i && take_i && irq_req_i && !ack_o;
  end
endmodule

// File: interrupt_priority_resolver.sv
`timescale 1ns/10ps
`include "irq_defines.svh"

// Contract
// - Each maskable vector gets one of four levels by software; NMI is not programmable.
// - NMI outranks every programmable level and any pending or active maskable interrupt; an active NMI handler holds off a new NMI.
// - Levels come from two register pairs: low/high for group a, group b.
// - A running handler is preempted by a request of strictly higher level.
// - No preemption by requests of equal or lower level than the active one.
// - A handler at the topmost level cannot be preempted by maskable sources.
// - Among simultaneous requests the highest level is serviced first.
// - Ties within a level are broken by a fixed polling order.
// - Polling positions 1-5: ext 0, timer 0, ext 1, timer 1, serial port.
// - Shared timer 2/divider/CAN/LIN vector sits at polling position six.
// - Shared ext 2/timer 21/serial 2/multiply/rotation vector sits at position nine.
// - Shared external 3 to 6 plus CAN vector sits at position ten.
// - Four capture/compare node-pointer vectors take positions eleven to fourteen.
// - One NMI vector with gated sources plus fourteen maskable vectors.
// - Each NMI source and each maskable vector has its own enable applied before arbitration.

// ==========================================================================
// Priority resolver between interrupt sources and the core.
// ==========================================================================
module interrupt_priority_resolver (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Non-maskable sources and their enables
  input  wire logic [`NUM_NMI_SRC-1:0] nmi_src_i,
  input  wire logic [`NUM_NMI_SRC-1:0] nmi_en_i,
  // Maskable vectors
  input  wire irq_pkg::vec_mask_t vec_req_i,
  input  wire irq_pkg::vec_mask_t vec_en_i,
  input  wire irq_pkg::vec_mask_t vec_clr_i,
  input  wire irq_pkg::prio_cfg_s prio_cfg_i,
  // Core handshake
  input  wire logic               ack_i,
  input  wire logic               ret_i,
  // Request to the core
  output logic                    irq_req_o,
  output logic                    irq_nmi_o,
  output irq_pkg::vec_idx_t       irq_vec_o,
  output irq_pkg::lvl_t           irq_lvl_o,
  // Status
  output irq_pkg::serv_t          in_service_o,
  output irq_pkg::vec_mask_t      pending_o
);

  irq_pkg::state_s    s_ff;
  irq_pkg::state_s    nxt_s;
  irq_pkg::pick_s     pick;
  irq_pkg::vec_mask_t cand;
  irq_pkg::vec_mask_t ack_mask;
  logic               nmi_set;
  logic               ack_take;
  logic               allowed;
  logic               higher_lvl;
  logic               earlier_same;

  // ========================================================================
  // Arbitration.
  // ========================================================================
  assign cand     = s_ff.pend & vec_en_i;
  assign nmi_set  = |(nmi_src_i & nmi_en_i);
  assign ack_take = s_ff.req && ack_i;
  assign ack_mask = irq_pkg::vec_mask_t'(ack_take && !s_ff.nmi) << s_ff.vec;

  priority_pick u_pick (
    .nmi_i  (s_ff.nmi_pend),
    .cand_i (cand),
    .cfg_i  (prio_cfg_i),
    .pick_o (pick)
  );

  always_comb
  begin
    if (pick.nmi)
    begin
      allowed = !s_ff.inserv[`NMI_SLOT];
    end
    else
    begin
      // Any handler at the same or a higher level blocks the candidate.
      allowed = !s_ff.inserv[`NMI_SLOT] &&
                ((s_ff.inserv[`NUM_LVL-1:0] & (`ALL_LVL_MASK << pick.lvl)) == 4'h0);
    end
  end

  // ========================================================================
  // Next state.
  // ========================================================================
  always_comb
  begin
    nxt_s = s_ff;
    if (ret_i)
    begin
      // The return ends the innermost handler, which is the highest in service.
      for (int l = 0; l <= `NMI_SLOT; l++)
      begin
        if (s_ff.inserv[l] && ((s_ff.inserv >> l) == irq_pkg::serv_t'(1)))
        begin
          nxt_s.inserv[l] = 1'b0;
        end
      end
    end
    if (ack_take)
    begin
      if (s_ff.nmi)
      begin
        nxt_s.nmi_pend          = 1'b0;
        nxt_s.inserv[`NMI_SLOT] = 1'b1;
      end
      else
      begin
        nxt_s.inserv[s_ff.lvl] = 1'b1;
      end
    end
    nxt_s.pend     = (s_ff.pend & ~vec_clr_i & ~ack_mask) | vec_req_i;
    nxt_s.nmi_pend = nxt_s.nmi_pend | nmi_set;
    nxt_s.req      = pick.valid && allowed && !ack_take;
    nxt_s.nmi      = pick.nmi;
    nxt_s.vec      = pick.vec;
    nxt_s.lvl      = pick.lvl;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign irq_req_o    = s_ff.req;
  assign irq_nmi_o    = s_ff.nmi;
  assign irq_vec_o    = s_ff.vec;
  assign irq_lvl_o    = s_ff.lvl;
  assign in_service_o = s_ff.inserv;
  assign pending_o    = s_ff.pend;

  // ========================================================================
  // Checks.
  // ========================================================================
  always_comb
  begin
    higher_lvl   = 1'b0;
    earlier_same = 1'b0;
    for (int i = 0; i < `NUM_VEC; i++)
    begin
      if (cand[i] && pick.valid && !pick.nmi)
      begin
        if (irq_pkg::level_of(prio_cfg_i, irq_pkg::vec_idx_t'(i)) > pick.lvl)
        begin
          higher_lvl = 1'b1;
        end
        if (irq_pkg::level_of(prio_cfg_i, irq_pkg::vec_idx_t'(i)) == pick.lvl &&
            irq_pkg::vec_idx_t'(i) < pick.vec)
        begin
          earlier_same = 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ack_seen;
    irq_req_o && ack_i && !ret_i;
  endsequence

  sequence req_dropped;
    !irq_req_o;
  endsequence

  level_first_a : assert property (!higher_lvl)
    else $error("a higher level candidate lost arbitration");

  poll_order_a : assert property (!earlier_same)
    else $error("a lower polling position lost within its level");

  nmi_wins_a : assert property (
    (s_ff.nmi_pend && !in_service_o[`NMI_SLOT] && !(irq_req_o && ack_i))
    |=> (irq_req_o && irq_nmi_o))
    else $error("pending NMI was not requested");

  nmi_shield_a : assert property (in_service_o[`NMI_SLOT] |=> !irq_req_o)
    else $error("request raised while NMI handler active");

  top_shield_a : assert property (
    in_service_o[`TOP_LVL] |=> !(irq_req_o && !irq_nmi_o))
    else $error("top level handler was preempted");

  strict_higher_a : assert property (
    (irq_req_o && !irq_nmi_o)
    |-> (($past(in_service_o[`NUM_LVL-1:0]) & (`ALL_LVL_MASK << irq_lvl_o)) == 4'h0))
    else $error("request not above the active level");

  enable_gate_a : assert property (
    (irq_req_o && !irq_nmi_o)
    |-> (($past(vec_en_i) & $past(pending_o) & (irq_pkg::vec_mask_t'(1) << irq_vec_o)) != '0))
    else $error("request for a disabled or idle vector");

  pend_hold_a : assert property (
    (($past(pending_o) & ~$past(vec_clr_i) & ~$past(ack_mask)) & ~pending_o) == '0)
    else $error("pending flag lost without service or clear");

  ack_serve_a : assert property (
    ack_seen |=> req_dropped ##0
    ($past(irq_nmi_o) ? in_service_o[`NMI_SLOT] : in_service_o[$past(irq_lvl_o)]))
    else $error("acknowledge did not enter the handler level");

  nmi_code_a : assert property (
    (irq_req_o && irq_nmi_o) |-> (irq_vec_o == `NMI_VEC && irq_lvl_o == `TOP_LVL))
    else $error("NMI request with wrong vector or level");

  ret_pop_a : assert property (
    (ret_i && !ack_take && in_service_o != '0) |=> (in_service_o < $past(in_service_o)))
    else $error("return did not end a handler");

endmodule

// File: irq_defines.svh
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ==========================================================================
// Sizes of the interrupt structure.
// ==========================================================================
`define NUM_VEC       14
`define NUM_NMI_SRC   6
`define VEC_W         4
`define LVL_W         2
`define NUM_LVL       4
`define CFG_W         8

// ==========================================================================
// Vector indices; the index is also the polling position minus one.
// ==========================================================================
`define VEC_EXT0      4'h0
`define VEC_TMR0      4'h1
`define VEC_EXT1      4'h2
`define VEC_TMR1      4'h3
`define VEC_UART      4'h4
`define VEC_SHARED6   4'h5
`define VEC_ADC       4'h6
`define VEC_SYNC_SERIAL 4'h7
`define VEC_SHARED9   4'h8
`define VEC_SHARED10  4'h9
`define VEC_NODE0     4'hA
`define VEC_NODE3     4'hD

// ==========================================================================
// Level grouping and codes.
// ==========================================================================
`define GROUP_A_SIZE  4'h7
`define NMI_SLOT      4
`define TOP_LVL       2'h3
`define NMI_VEC       4'hE
`define ALL_LVL_MASK  4'hF

`endif

// File: irq_pkg.sv
`include "irq_defines.svh"

package irq_pkg;

  typedef logic [`NUM_VEC-1:0] vec_mask_t;
  typedef logic [`VEC_W-1:0]   vec_idx_t;
  typedef logic [`LVL_W-1:0]   lvl_t;
  typedef logic [`NUM_LVL:0]   serv_t;

  // Two pairs of priority bytes; pair a covers vectors 0 to 6, pair b 7 to 13.
  typedef struct packed {
    logic [`CFG_W-1:0] prio_low_bits_a;
    logic [`CFG_W-1:0] prio_high_bits_a;
    logic [`CFG_W-1:0] prio_low_bits_b;
    logic [`CFG_W-1:0] prio_high_bits_b;
  } prio_cfg_s;

  typedef struct packed {
    logic     valid;
    logic     nmi;
    vec_idx_t vec;
    lvl_t     lvl;
  } pick_s;

  typedef struct packed {
    vec_mask_t pend;
    logic      nmi_pend;
    serv_t     inserv;
    logic      req;
    logic      nmi;
    vec_idx_t  vec;
    lvl_t      lvl;
  } state_s;

  // Level of a maskable vector: the high bit comes from the high byte.
  function automatic lvl_t level_of(input prio_cfg_s c, input vec_idx_t i);
    vec_idx_t j;
    lvl_t     l;
    j = vec_idx_t'(i - `GROUP_A_SIZE);
    if (i < `GROUP_A_SIZE)
    begin
      l = {c.prio_high_bits_a[i[2:0]], c.prio_low_bits_a[i[2:0]]};
    end
    else
    begin
      l = {c.prio_high_bits_b[j[2:0]], c.prio_low_bits_b[j[2:0]]};
    end
    return l;
  endfunction

endpackage

// File: priority_pick.sv
`timescale 1ns/10ps
`include "irq_defines.svh"

// ==========================================================================
// Combinational winner selection among requests that may be serviced.
// ==========================================================================
module priority_pick (
  // Candidates
  input  wire logic              nmi_i,
  input  wire irq_pkg::vec_mask_t cand_i,
  input  wire irq_pkg::prio_cfg_s cfg_i,
  // Winner
  output irq_pkg::pick_s          pick_o
);

  irq_pkg::lvl_t lv;

  always_comb
  begin
    pick_o = '0;
    lv     = '0;
    // Walking down means a tie at the same level goes to the lower index.
    for (int i = `NUM_VEC - 1; i >= 0; i--)
    begin
      lv = irq_pkg::level_of(cfg_i, irq_pkg::vec_idx_t'(i));
      if (cand_i[i] && (!pick_o.valid || lv >= pick_o.lvl))
      begin
        pick_o.valid = 1'b1;
        pick_o.vec   = irq_pkg::vec_idx_t'(i);
        pick_o.lvl   = lv;
      end
    end
    if (nmi_i)
    begin
      pick_o.valid = 1'b1;
      pick_o.nmi   = 1'b1;
      pick_o.vec   = `NMI_VEC;
      pick_o.lvl   = `TOP_LVL;
    end
  end

endmodule

// File: tb.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t: %s", $time, m); end end

module tb;
  logic               ref_clk_i, rst_n_i, take, ack_i, ret_i;
  logic [5:0]         nmi_src_i, nmi_en_i;
  irq_pkg::vec_mask_t vec_req_i, vec_en_i, vec_clr_i, pending_o;
  irq_pkg::prio_cfg_s cfg;
  logic               irq_req_o, irq_nmi_o;
  irq_pkg::vec_idx_t  irq_vec_o;
  irq_pkg::lvl_t      irq_lvl_o;
  irq_pkg::serv_t     in_service_o;
  int                 miscompares, n_compared;

  interrupt_priority_resolver i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .nmi_src_i(nmi_src_i), .nmi_en_i(nmi_en_i), .vec_req_i(vec_req_i),
    .vec_en_i(vec_en_i), .vec_clr_i(vec_clr_i), .prio_cfg_i(cfg), .ack_i(ack_i),
    .ret_i(ret_i), .irq_req_o(irq_req_o), .irq_nmi_o(irq_nmi_o),
    .irq_vec_o(irq_vec_o), .irq_lvl_o(irq_lvl_o), .in_service_o(in_service_o),
    .pending_o(pending_o));
  core_model i_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o),
    .take_i(take), .ack_o(ack_i));

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic set_lvl(input int v, input irq_pkg::lvl_t l);
    if (v < 7)
    begin
      cfg.prio_low_bits_a[v] = l[0];
      cfg.prio_high_bits_a[v] = l[1];
    end
    else
    begin
      cfg.prio_low_bits_b[v-7] = l[0];
      cfg.prio_high_bits_b[v-7] = l[1];
    end
  endtask

  task automatic raise(input irq_pkg::vec_mask_t m);
    vec_req_i = m;
    tick();
    vec_req_i = '0;
  endtask

  task automatic expect_req(input irq_pkg::vec_idx_t v, input irq_pkg::lvl_t l, input logic n);
    int k;
    k = 0;
    while (irq_req_o !== 1'b1 && k < 8)
    begin
      tick();
      k++;
    end
    `CHK(irq_req_o, 1'b1, "no request")
    `CHK(irq_vec_o, v, "vector")
    `CHK(irq_lvl_o, l, "level")
    `CHK(irq_nmi_o, n, "nmi flag")
  endtask

  task automatic no_req();
    logic seen;
    seen = 1'b0;
    repeat (5)
    begin
      tick();
      seen = seen | (irq_req_o !== 1'b0);
    end
    `CHK(seen, 1'b0, "unexpected request")
  endtask

  task automatic accept();
    int k;
    k = 0;
    take = 1'b1;
    while (ack_i !== 1'b1 && k < 8)
    begin
      tick();
      k++;
    end
    tick();
    take = 1'b0;
  endtask

  task automatic retn();
    ret_i = 1'b1;
    tick();
    ret_i = 1'b0;
    tick();
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_basic();
    cfg = '0;
    vec_en_i = 14'h3FFD;
    raise(14'h0002);
    `CHK(pending_o, 14'h0002, "pending")
    no_req();
    vec_en_i = 14'h3FFF;
    expect_req(4'h1, 2'h0, 1'b0);
    accept();
    `CHK(in_service_o, 5'h01, "in service")
    `CHK(pending_o, 14'h0000, "pending cleared")
    vec_en_i = 14'h3FF7;
    raise(14'h0008);
    vec_clr_i = 14'h0008;
    tick();
    vec_clr_i = '0;
    `CHK(pending_o, 14'h0000, "software clear")
    retn();
    `CHK(in_service_o, 5'h00, "return")
    $display("t_basic done");
  endtask

  task automatic t_poll();
    vec_en_i = 14'h3FFF;
    raise(14'h3FFF);
    for (int i = 0; i < 14; i++)
    begin
      expect_req(4'(i), 2'h0, 1'b0);
      accept();
      retn();
    end
    $display("t_poll done");
  endtask

  task automatic t_level();
    irq_pkg::vec_idx_t ord[4] = '{4'hD, 4'h6, 4'h8, 4'h0};
    set_lvl(13, 2'h3);
    set_lvl(6, 2'h2);
    set_lvl(8, 2'h1);
    raise(14'h2141);
    for (int i = 0; i < 4; i++)
    begin
      expect_req(ord[i], 2'(3 - i), 1'b0);
      accept();
      retn();
    end
    $display("t_level done");
  endtask

  task automatic t_preempt();
    cfg = '0;
    set_lvl(2, 2'h1);
    set_lvl(0, 2'h1);
    set_lvl(5, 2'h2);
    set_lvl(9, 2'h3);
    set_lvl(4, 2'h3);
    raise(14'h0004);
    expect_req(4'h2, 2'h1, 1'b0);
    accept();
    raise(14'h0001);
    no_req();
    raise(14'h0020);
    expect_req(4'h5, 2'h2, 1'b0);
    accept();
    raise(14'h0200);
    expect_req(4'h9, 2'h3, 1'b0);
    accept();
    `CHK(in_service_o, 5'h0E, "nested levels")
    raise(14'h0010);
    no_req();
    nmi_en_i = 6'h01;
    nmi_src_i = 6'h01;
    tick();
    nmi_src_i = '0;
    expect_req(4'hE, 2'h3, 1'b1);
    accept();
    `CHK(in_service_o, 5'h1E, "nmi in service")
    vec_clr_i = 14'h3FFF;
    tick();
    vec_clr_i = '0;
    repeat (4) retn();
    `CHK(in_service_o, 5'h00, "all returned")
    $display("t_preempt done");
  endtask

  task automatic t_nmi();
    for (int k = 0; k < 6; k++)
    begin
      nmi_en_i = ~(6'h01 << k);
      nmi_src_i = 6'h01 << k;
      tick();
      nmi_src_i = '0;
      no_req();
      nmi_en_i = 6'h01 << k;
      nmi_src_i = 6'h01 << k;
      tick();
      nmi_src_i = '0;
      expect_req(4'hE, 2'h3, 1'b1);
      accept();
      retn();
    end
    $display("t_nmi done");
  endtask

  task automatic results();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    #100000;
    miscompares++;
    results();
  end

  initial
  begin
    {rst_n_i, take, ret_i, nmi_src_i, nmi_en_i} = '0;
    {vec_req_i, vec_en_i, vec_clr_i, cfg} = '0;
    repeat (5) tick();
    rst_n_i = 1'b1;
    `CHK(in_service_o, 5'h00, "reset state")
    t_basic();
    t_poll();
    t_level();
    t_preempt();
    t_nmi();
    results();
  end
endmodule
